// ==== design/spi_master_slave_port.sv ====
// Serial peripheral port, clock master or slave, behind AXI4-Lite
// Assumes pins come from outside the clock domain; sleep/idle from core logic
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
module spi_master_slave_port #(
    parameter int ADDR_W = 4
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              sleep_mode,
    input  wire logic              cpu_idle,
    input  wire logic              shift_clock_pin_i,
    output logic                   shift_clock_pin_o,
    output logic                   shift_clock_pin_oe,
    input  wire logic              serial_in_pin,
    output logic                   serial_out_pin_o,
    output logic                   serial_out_pin_oe,
    input  wire logic              slave_select_pin_i,
    output logic                   slave_select_pin_o,
    output logic                   slave_select_pin_oe,
    output logic                   port_irq
);

    if (ADDR_W < 4)
    begin : g_bad_addr_w
        $error("ADDR_W must be at least 4");
    end

    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic                      arready;
        logic                      rvalid;
        logic                      aw_ok;
        logic                      w_ok;
        logic                      aw_bad;
        logic [1:0]                aw_idx;
        logic [15:0]               wd;
        logic [1:0]                ws;
        logic [1:0]                bresp;
        logic [1:0]                rresp;
        logic [15:0]               rdata;
        logic                      en;
        logic                      idle_stop;
        logic                      ovr;
        logic                      tbf;
        logic                      rbf;
        logic                      irq_flag;
        logic                      irq_en;
        logic                      irq;
        logic [15:0]               ctl;
        logic [15:0]               txb;
        logic [15:0]               rxb;
        logic [15:0]               sr;
        logic [3:0]                cnt;
        spi_port_pkg::xfer_state_t st;
        logic                      sck_o;
        logic                      sck_oe;
        logic                      sdo_o;
        logic                      sdo_oe;
        logic                      ss_o;
        logic                      ss_oe;
        logic                      armed;
        logic                      sck_a;
        logic                      sck_b;
        logic                      sck_c;
        logic                      sdi_a;
        logic                      sdi_b;
        logic                      ss_a;
        logic                      ss_b;
    } port_state_t;

    localparam port_state_t RESET_STATE = '{
        ctl:     spi_port_pkg::CONTROL_RESET,
        txb:     spi_port_pkg::BUFFER_RESET,
        rxb:     spi_port_pkg::BUFFER_RESET,
        st:      spi_port_pkg::ST_IDLE,
        default: '0
    };

    port_state_t r;
    port_state_t next_r;
    logic        tick;
    logic        master;
    logic        framed;
    logic        fs_in;
    logic        cke;
    logic        clock_idle_polarity;
    logic        width16;
    logic [3:0]  last;

    assign master  = r.ctl[spi_port_pkg::CT_MASTER];
    assign framed  = r.ctl[spi_port_pkg::CT_FRAMED];
    assign fs_in   = r.ctl[spi_port_pkg::CT_FS_DIR];
    assign cke     = r.ctl[spi_port_pkg::CT_EDGE];
    assign clock_idle_polarity     = r.ctl[spi_port_pkg::CT_IDLE_POL];
    assign width16 = r.ctl[spi_port_pkg::CT_WIDTH16];
    assign last    = width16 ? spi_port_pkg::LAST_BIT_16 : spi_port_pkg::LAST_BIT_8;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] d,
                                            input logic [1:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ----------------------------------------------------------------
    // Master shift clock prescaler
    // ----------------------------------------------------------------
    spi_shift_clock_divider #(
        .CNT_W (11)
    ) u_div (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .run                (r.st != spi_port_pkg::ST_IDLE),
        .restart            (r.st == spi_port_pkg::ST_IDLE),
        .primary_prescale   (r.ctl[spi_port_pkg::CT_PPRE_LSB +: 2]),
        .secondary_prescale (r.ctl[spi_port_pkg::CT_SPRE_LSB +: 3]),
        .tick               (tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [15:0] sw;
        logic [15:0] wv;
        logic        wr_go;
        logic        active;
        logic        port_reset;
        logic        edge_hit;
        logic        lead;
        logic        done;
        logic        sel;
        logic        sck_edge;
        logic        tx_wr;
        sw = '0;
        wv = '0;
        wr_go = 1'b0;
        active = 1'b0;
        port_reset = 1'b0;
        edge_hit = 1'b0;
        lead = 1'b0;
        done = 1'b0;
        sel = 1'b0;
        sck_edge = 1'b0;
        tx_wr = 1'b0;
        next_r = r;

        next_r.sck_a = shift_clock_pin_i;
        next_r.sck_b = r.sck_a;
        next_r.sck_c = r.sck_b;
        next_r.sdi_a = serial_in_pin;
        next_r.sdi_b = r.sdi_a;
        next_r.ss_a = slave_select_pin_i;
        next_r.ss_b = r.ss_a;

        sw[spi_port_pkg::ST_ENABLE] = r.en;
        sw[spi_port_pkg::ST_IDLE_STOP] = r.idle_stop;
        sw[spi_port_pkg::ST_OVERRUN] = r.ovr;
        sw[spi_port_pkg::ST_TX_FULL] = r.tbf;
        sw[spi_port_pkg::ST_RX_FULL] = r.rbf;

        // Register read; a buffer read empties the receive side
        if (r.rvalid && rready)
            next_r.rvalid = 1'b0;
        if (r.arready && arvalid)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp = spi_port_pkg::RESP_OKAY;
            next_r.rdata = '0;
            if ((araddr >> 4) != '0)
                next_r.rresp = spi_port_pkg::RESP_SLVERR;
            else
                unique case ({araddr[3:2], 2'b00})
                    spi_port_pkg::OFS_STATUS:  next_r.rdata = sw;
                    spi_port_pkg::OFS_CONTROL: next_r.rdata = r.ctl;
                    spi_port_pkg::OFS_BUFFER:
                    begin
                        next_r.rdata = r.rxb;
                        next_r.rbf = 1'b0;
                        next_r.ovr = 1'b0;
                    end
                    spi_port_pkg::OFS_IRQ:
                    begin
                        next_r.rdata[spi_port_pkg::IR_FLAG] = r.irq_flag;
                        next_r.rdata[spi_port_pkg::IR_ENABLE] = r.irq_en;
                    end
                endcase
        end

        // Register write; address and data taken in either order
        if (r.awready && awvalid)
        begin
            next_r.aw_ok = 1'b1;
            next_r.aw_idx = awaddr[3:2];
            next_r.aw_bad = (awaddr >> 4) != '0;
        end
        if (r.wready && wvalid)
        begin
            next_r.w_ok = 1'b1;
            next_r.wd = wdata[15:0];
            next_r.ws = wstrb[1:0];
        end
        if (r.bvalid && bready)
            next_r.bvalid = 1'b0;
        wr_go = r.aw_ok && r.w_ok && !r.bvalid;
        if (wr_go)
        begin
            next_r.aw_ok = 1'b0;
            next_r.w_ok = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = r.aw_bad ? spi_port_pkg::RESP_SLVERR : spi_port_pkg::RESP_OKAY;
        end
        if (wr_go && !r.aw_bad)
            unique case ({r.aw_idx, 2'b00})
                spi_port_pkg::OFS_STATUS:
                begin
                    wv = merge16(sw, r.wd, r.ws);
                    next_r.en = wv[spi_port_pkg::ST_ENABLE];
                    next_r.idle_stop = wv[spi_port_pkg::ST_IDLE_STOP];
                    if (!wv[spi_port_pkg::ST_OVERRUN])
                        next_r.ovr = 1'b0;
                end
                spi_port_pkg::OFS_CONTROL:
                begin
                    wv = merge16(r.ctl, r.wd, r.ws);
                    next_r.ctl = wv;
                    port_reset = wv[spi_port_pkg::CT_WIDTH16] != width16;
                end
                spi_port_pkg::OFS_BUFFER:
                begin
                    next_r.txb = merge16(r.txb, r.wd, r.ws);
                    next_r.tbf = 1'b1;
                    tx_wr = 1'b1;
                end
                spi_port_pkg::OFS_IRQ:
                begin
                    if (r.ws[0] && r.wd[spi_port_pkg::IR_FLAG])
                        next_r.irq_flag = 1'b0;
                    if (r.ws[0])
                        next_r.irq_en = r.wd[spi_port_pkg::IR_ENABLE];
                end
            endcase

        active = r.en && !sleep_mode && !(cpu_idle && r.idle_stop);

        // ------------------------------------------------------------
        // Master sequencing, clocks from the prescaler
        // ------------------------------------------------------------
        if (active && master && !port_reset)
            unique case (r.st)
                spi_port_pkg::ST_IDLE:
                begin
                    next_r.sck_o = clock_idle_polarity;
                    if (r.tbf && !r.ovr && (!framed || !fs_in || r.ss_b))
                    begin
                        next_r.sr = r.txb;
                        next_r.tbf = tx_wr;
                        next_r.cnt = '0;
                        next_r.sdo_o = r.txb[last];
                        next_r.ss_o = framed && !fs_in;
                        next_r.st = (framed && !fs_in) ? spi_port_pkg::ST_FRAME
                                                       : spi_port_pkg::ST_SHIFT;
                    end
                end
                spi_port_pkg::ST_FRAME:
                    if (tick)
                    begin
                        next_r.sck_o = !r.sck_o;
                        if (r.sck_o != clock_idle_polarity)
                        begin
                            next_r.ss_o = 1'b0;
                            next_r.st = spi_port_pkg::ST_SHIFT;
                        end
                    end
                spi_port_pkg::ST_SHIFT:
                    if (tick)
                    begin
                        next_r.sck_o = !r.sck_o;
                        edge_hit = 1'b1;
                        lead = r.sck_o == clock_idle_polarity;
                    end
                spi_port_pkg::ST_TAIL:
                    if (tick)
                    begin
                        next_r.sck_o = clock_idle_polarity;
                        next_r.st = spi_port_pkg::ST_IDLE;
                    end
            endcase

        // ------------------------------------------------------------
        // Slave sequencing, clocks from the pin
        // ------------------------------------------------------------
        sel = framed || !r.ctl[spi_port_pkg::CT_SEL_CTL] || !r.ss_b;
        sck_edge = r.sck_b != r.sck_c;
        if (active && !master && !port_reset)
        begin
            if (!sel)
            begin
                next_r.cnt = '0;
                next_r.armed = 1'b0;
            end
            else if (sck_edge && !r.ovr)
            begin
                if (framed && !r.armed && r.cnt == '0)
                begin
                    if (r.sck_b != clock_idle_polarity)
                    begin
                        next_r.armed = fs_in ? r.ss_b : 1'b1;
                        next_r.ss_o = !fs_in;
                    end
                end
                else
                begin
                    edge_hit = 1'b1;
                    lead = r.sck_b != clock_idle_polarity;
                    if (lead)
                        next_r.ss_o = 1'b0;
                end
            end
            else if (r.cnt == '0 && r.tbf)
            begin
                next_r.sr = r.txb;
                next_r.tbf = tx_wr;
                next_r.sdo_o = r.txb[last];
            end
        end

        // ------------------------------------------------------------
        // Shared shifter: sample on one transition, drive on the other
        // ------------------------------------------------------------
        if (edge_hit)
        begin
            if (lead == cke)
            begin
                next_r.sr = {r.sr[14:0], r.sdi_b};
                done = r.cnt == last;
                next_r.cnt = done ? 4'h0 : r.cnt + 4'h1;
            end
            else
            begin
                next_r.sdo_o = r.sr[last];
            end
        end
        if (done)
        begin
            next_r.irq_flag = 1'b1;
            next_r.armed = 1'b0;
            if (master)
                next_r.st = lead ? spi_port_pkg::ST_TAIL : spi_port_pkg::ST_IDLE;
            if (next_r.rbf)
                next_r.ovr = 1'b1;
            else
            begin
                next_r.rxb = width16 ? next_r.sr : {8'h00, next_r.sr[7:0]};
                next_r.rbf = 1'b1;
            end
        end

        // Disable, sleep and width change abort; registers kept, except that a width change also clears the full and overrun flags
        if (!r.en || sleep_mode || port_reset)
        begin
            next_r.st = spi_port_pkg::ST_IDLE;
            next_r.cnt = '0;
            next_r.armed = 1'b0;
            next_r.ss_o = 1'b0;
            next_r.sck_o = next_r.ctl[spi_port_pkg::CT_IDLE_POL];
        end
        if (port_reset)
        begin
            next_r.tbf = 1'b0;
            next_r.rbf = 1'b0;
            next_r.ovr = 1'b0;
        end

        next_r.sck_oe = r.en && master;
        next_r.sdo_oe = r.en && !r.ctl[spi_port_pkg::CT_SDO_DIS] && (master || sel);
        next_r.ss_oe = r.en && framed && !fs_in;
        next_r.irq = next_r.irq_flag && next_r.irq_en;
        next_r.awready = !next_r.aw_ok && !next_r.bvalid;
        next_r.wready = !next_r.w_ok && !next_r.bvalid;
        next_r.arready = !next_r.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= RESET_STATE;
        else
            r <= next_r;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign awready             = r.awready;
    assign wready              = r.wready;
    assign bresp               = r.bresp;
    assign bvalid              = r.bvalid;
    assign arready             = r.arready;
    assign rdata               = {16'h0000, r.rdata};
    assign rresp               = r.rresp;
    assign rvalid              = r.rvalid;
    assign shift_clock_pin_o   = r.sck_o;
    assign shift_clock_pin_oe  = r.sck_oe;
    assign serial_out_pin_o    = r.sdo_o;
    assign serial_out_pin_oe   = r.sdo_oe;
    assign slave_select_pin_o  = r.ss_o;
    assign slave_select_pin_oe = r.ss_oe;
    assign port_irq            = r.irq;

endmodule : spi_master_slave_port

// ==== common/spi_port_pkg.sv ====
// Constants, register map and types of the serial port
// Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock
package spi_port_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_STATUS  = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_BUFFER  = 4'h8;
    localparam logic [3:0] OFS_IRQ     = 4'hC;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ST_ENABLE    = 15;
    localparam int ST_IDLE_STOP = 13;
    localparam int ST_OVERRUN   = 6;
    localparam int ST_TX_FULL   = 1;
    localparam int ST_RX_FULL   = 0;
    localparam int CT_FRAMED    = 14;
    localparam int CT_FS_DIR    = 13;
    localparam int CT_SDO_DIS   = 11;
    localparam int CT_WIDTH16   = 10;
    localparam int CT_EDGE      = 8;
    localparam int CT_SEL_CTL   = 7;
    localparam int CT_IDLE_POL  = 6;
    localparam int CT_MASTER    = 5;
    localparam int CT_SPRE_LSB  = 2;
    localparam int CT_PPRE_LSB  = 0;
    localparam int IR_FLAG      = 0;
    localparam int IR_ENABLE    = 1;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] BUFFER_RESET  = 16'h0000;
    localparam logic [3:0]  LAST_BIT_8    = 4'h7;
    localparam logic [3:0]  LAST_BIT_16   = 4'hF;
    localparam int          BASE_DIV      = 4;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_SHIFT, ST_TAIL} xfer_state_t;

endpackage : spi_port_pkg

// ==== design/spi_shift_clock_divider.sv ====
// Half-period tick generator for the master shift clock
// Assumes one clock; tick is a one-cycle enable pulse
module spi_shift_clock_divider #(
    parameter int CNT_W = 11
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [1:0] primary_prescale,
    input  wire logic [2:0] secondary_prescale,
    output logic            tick
);

    if (CNT_W < 11)
    begin : g_bad_cnt_w
        $error("CNT_W too small for largest divide");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } div_state_t;

    div_state_t r;
    div_state_t next_r;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] pdiv;
    logic [CNT_W-1:0] sdiv;

    // ----------------------------------------------------------------
    // Base rate is one quarter of the clock, then two prescalers
    // ----------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        pdiv = CNT_W'(1) << (2 * (3 - primary_prescale));
        sdiv = CNT_W'(8 - secondary_prescale);
        limit = CNT_W'((spi_port_pkg::BASE_DIV / 2) * pdiv * sdiv - 1);
        next_r.tick = 1'b0;
        if (restart)
        begin
            next_r.cnt = '0;
        end
        else if (run)
        begin
            if (r.cnt >= limit)
            begin
                next_r.cnt = '0;
                next_r.tick = 1'b1;
            end
            else
            begin
                next_r.cnt = r.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign tick = r.tick;

endmodule : spi_shift_clock_divider

// ==== tb/spi_port_sva.sv ====
// Assertions on the register bus and the shift clock pin
// Assumes binding to every spi_master_slave_port instance
module spi_port_sva (
    input wire logic        aclk, aresetn, awready, wready, bvalid, bready, arvalid,
    input wire logic        arready, rvalid, rready, sleep_mode, shift_clock_pin_o,
    input wire logic [31:0] rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer withdrawn");
    a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer changed");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_rvalid_drop: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    a_ar_blocked: assert property (rvalid |-> !arready)
        else $error("read taken while answering");
    a_aw_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
    a_rdata_upper: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_sleep_still: assert property (sleep_mode [*3] |-> $stable(shift_clock_pin_o))
        else $error("shift clock moves in sleep");
endmodule : spi_port_sva
bind spi_master_slave_port spi_port_sva u_sva (.*);

// ==== tb/spi_far_end.sv ====
// Far-end serial device: samples on the rising clock, shifts on the falling one
// Assumes an idle-low shift clock from the port in master mode
module spi_far_end (
    input wire logic        sck, sdo, load,
    input wire logic [15:0] send,
    output logic            sdi,
    output logic [15:0]     got
);
    logic [15:0] sh;
    always @(posedge sck) got <= {got[14:0], sdo};
    always @(negedge sck or posedge load) sh <= load ? send : {sh[14:0], ~sh[0]};
    assign sdi = sh[15];
endmodule : spi_far_end

// ==== tb/spi_master_slave_port_test.sv ====
// Self-checking bench: AXI4-Lite master, far-end model, result queues
// Assumes the port runs as master with the far end on its pins
module spi_master_slave_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, sleep_mode = 0, load = 0, cpu_idle = 0;
    logic [4:0] awaddr = 0, araddr = 0;
    logic [2:0] awprot = 0, arprot = 0;
    logic [31:0] wdata = 0;
    logic [15:0] send = 0, d, p, q;
    wire logic awready, wready, bvalid, arready, rvalid, port_irq, sck, sck_oe, sdo, sdi;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] got;
    wire logic sdo_oe, ss_oe, ss_o;
    wire logic sck_w = sck_oe & sck;
    logic [33:0] rq[$], er;
    logic [1:0] bq[$], eb;
    int n_fail = 0, check_count = 0;
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
    always #4 aclk = ~aclk;
    spi_master_slave_port #(.ADDR_W(5)) DUT (.*, .wstrb(4'hF),
        .shift_clock_pin_i(1'b0), .shift_clock_pin_o(sck), .shift_clock_pin_oe(sck_oe),
        .serial_in_pin(sdi), .serial_out_pin_o(sdo), .serial_out_pin_oe(sdo_oe),
        .slave_select_pin_i(1'b1), .slave_select_pin_o(ss_o), .slave_select_pin_oe(ss_oe));
    spi_far_end far (.sck(sck_w), .sdo(sdo), .load(load), .send(send), .sdi(sdi), .got(got));
    always @(posedge aclk)
    begin
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            er = rq.pop_front();
            `CHK({rresp, rdata}, er)
        end
        if (bvalid === 1'b1 && bready === 1'b1)
        begin
            eb = bq.pop_front();
            `CHK(bresp, eb)
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [4:0] a, input logic [15:0] v, input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= {16'h0000, v};
        awprot <= 3'($urandom);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        repeat ($urandom % 3) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arprot <= 3'($urandom);
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat ($urandom % 3) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd
    task automatic xfer(input logic w16, output logic [15:0] rx);
        d = w16 ? 16'($urandom) : {8'h00, 8'($urandom)};
        rx = w16 ? 16'($urandom) : {8'h00, 8'($urandom)};
        send <= w16 ? rx : {rx[7:0], 8'h00};
        load <= 1'b1;
        @(posedge aclk);
        load <= 1'b0;
        wr(5'h08, d, 2'b00);
        if (w16)
        begin
            repeat (40) @(posedge aclk);
            cpu_idle <= 1'b1;
            repeat (300) @(posedge aclk);
            `CHK(port_irq, 1'b0)
            cpu_idle <= 1'b0;
        end
        repeat (6000) begin @(posedge aclk); if (port_irq === 1'b1) break; end
        `CHK(port_irq, 1'b1)
        `CHK(w16 ? got : {8'h00, got[7:0]}, d)
        `CHK({sdo_oe, ss_oe, ss_o}, 3'b100)
        wr(5'h0C, 16'h0003, 2'b00);
    endtask : xfer
    initial
    begin
        void'($urandom(35));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(5'h04, 34'h0);
        rd(5'h10, {2'b10, 32'h0});
        wr(5'h10, 16'hFFFF, 2'b10);
        wr(5'h0C, 16'h0002, 2'b00);
        wr(5'h04, 16'h0133, 2'b00);
        wr(5'h00, 16'h8000, 2'b00);
        xfer(1'b0, p);
        xfer(1'b0, q);
        rd(5'h00, {18'h0, 16'h8041});
        rd(5'h08, {18'h0, p});
        wr(5'h00, 16'h0000, 2'b00);
        wr(5'h04, 16'h0533, 2'b00);
        wr(5'h00, 16'hA000, 2'b00);
        xfer(1'b1, p);
        rd(5'h08, {18'h0, p});
        rd(5'h0C, {18'h0, 16'h0002});
        wr(5'h08, 16'($urandom), 2'b00);
        repeat (40) @(posedge aclk);
        sleep_mode <= 1'b1;
        repeat (300) @(posedge aclk);
        sleep_mode <= 1'b0;
        rd(5'h04, {18'h0, 16'h0533});
        `CHK(port_irq, 1'b0)
        give_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        give_verdict;
    end
endmodule : spi_master_slave_port_test
